/* bench/msp_servo_load.sv */
// Servo load model: counts pulses and high width on the pins.
// Assumes pins registered to core_clk; it only listens.
`timescale 1ns/1ps
`default_nettype none
module msp_servo_load(
  input  wire logic        core_clk,  // clk
  input  wire logic [31:0] servo_pin, // pins
  output wire logic [31:0] edges,     // pulses
  output wire logic [31:0] hi_len     // last high
);
  logic        prev   = 1'b0;
  int          run    = 0;
  logic [31:0] n_edge = 32'h0;
  logic [31:0] n_hi   = 32'h0;
  assign edges  = n_edge;
  assign hi_len = n_hi;
  // Any pin counts, so the bench may pick any channel
  always @(posedge core_clk) begin
    prev <= |servo_pin;
    if (|servo_pin) begin
      run <= run + 1;
      if (!prev) n_edge <= n_edge + 32'h1;
    end else begin
      if (prev) n_hi <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

/* bench/msp_servo_monitor.sv */
// Port checker for the servo block.
// Bound to msp_servo; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module msp_servo_monitor(
  input wire logic        core_clk,   // clk
  input wire logic        nrst,       // rst
  input wire logic        cfg_rd,     // rd
  input wire logic [7:0]  cfg_addr,   // ofs
  input wire logic [31:0] cfg_rdata,  // data
  input wire logic        io_wr,      // wr
  input wire logic        io_rd,      // rd
  input wire logic [15:0] io_addr,    // addr
  input wire logic [31:0] io_wdata,   // data
  input wire logic [31:0] io_rdata,   // data
  input wire logic        io_hit,     // hit
  input wire logic        serial_off, // free
  input wire logic [31:0] servo_pin,  // pins
  input wire logic [15:0] irq_line    // irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence lock_all;
    io_wr && io_addr[8:0] == 9'h008 && &io_wdata ##1 io_hit;
  endsequence
  low_zero_a: assert property (cfg_rd |=> cfg_rdata[8:0] == 9'h000)
    else $error("cfg low bits set");
  rsvd_zero_a: assert property (cfg_rd |=>
    cfg_rdata[31:25] == 7'h00 && cfg_rdata[22:20] == 3'h0)
    else $error("cfg reserved bits set");
  cfg_miss_a: assert property (cfg_rd && cfg_addr[7:2] != 6'h34
    |=> cfg_rdata == 32'h0) else $error("cfg miss not zero");
  idle_hit_a: assert property (!(io_rd || io_wr) |=> !io_hit)
    else $error("hit without access");
  miss_read_a: assert property (io_rd ##1 !io_hit |-> io_rdata == 32'h0)
    else $error("undecoded read not zero");
  pin_gate_a: assert property (!serial_off |=> servo_pin == 32'h0)
    else $error("pins driven while shared");
  irq_one_a: assert property ($onehot0(irq_line))
    else $error("several irq lines");
  irq_unused_a: assert property ((irq_line & 16'h2105) == 16'h0)
    else $error("unrouted irq line");
  lock_low_a: assert property (lock_all |=> servo_pin == 32'h0)
    else $error("locked pin high");
endmodule
bind msp_servo msp_servo_monitor msp_servo_monitor_inst(.core_clk(core_clk),
  .nrst(nrst), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
  .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .io_hit(io_hit), .serial_off(serial_off),
  .servo_pin(servo_pin), .irq_line(irq_line));
`default_nettype wire

/* bench/multichannel_servo_pwm_control_tb.sv */
// Self-checking bench for msp_servo.
// Monitor is bound; servo load sits on the pins.
`timescale 1ns/1ps
`default_nettype none
module multichannel_servo_pwm_control_tb;
  logic        core_clk = 0, nrst = 0, serial_off = 0, rd_d = 0, sel_d = 0;
  logic        cfg_wr = 0, cfg_rd = 0, io_wr = 0, io_rd = 0, io_hit;
  logic [7:0]  cfg_addr = 8'h00;
  logic [15:0] io_addr = 16'h0, base, irq_line;
  logic [31:0] cfg_wdata = 0, io_wdata = 0, cfg_rdata, io_rdata, servo_pin;
  logic [31:0] exp_q[$], msk_q[$];
  int          error_cnt = 0, total_checks = 0, cyc = 0, edges, hi_len, e0, ch;
  int          irqn[16] = '{0,9,3,10,4,5,7,6,1,11,0,12,0,14,0,15};
  always #10 core_clk = ~core_clk;
  msp_servo msp_servo_inst(.core_clk(core_clk), .nrst(nrst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
    .serial_off(serial_off), .servo_pin(servo_pin), .irq_line(irq_line));
  msp_servo_load msp_servo_load_inst(.core_clk(core_clk),
    .servo_pin(servo_pin), .edges(edges), .hi_len(hi_len));
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reads note the masked expectation; the watcher compares it
  task automatic acc(input logic io, wr, input logic [15:0] a,
                     input logic [31:0] d, m);
    if (!wr) exp_q.push_back(d);
    if (!wr) msk_q.push_back(m);
    io_addr = a;
    cfg_addr = a[7:0];
    io_wdata = d;
    cfg_wdata = d;
    {io_wr, io_rd, cfg_wr, cfg_rd} = {io & wr, io & !wr, !io & wr, !io & !wr};
    @(negedge core_clk);
    {io_wr, io_rd, cfg_wr, cfg_rd} = 4'h0;
    @(negedge core_clk);
  endtask
  always @(posedge core_clk) begin
    rd_d <= cfg_rd | io_rd;
    sel_d <= io_rd;
  end
  always @(negedge core_clk) if (rd_d) begin
    chk((sel_d ? io_rdata : cfg_rdata) & msk_q[0], exp_q.pop_front());
    void'(msk_q.pop_front());
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      close_out;
    end
  end
  initial begin
    void'($urandom(8));
    base = 16'($urandom) & 16'hfe00;
    ch = $urandom_range(31);
    repeat (16) @(negedge core_clk);
    nrst = 1;
    acc(0, 0, 16'h00d0, 32'h0, '1);
    acc(0, 1, 16'h00d0, '1, 0);
    acc(0, 0, 16'h00d0, 32'h018f_fe00, '1);
    acc(0, 0, 16'h00d4, 32'h0, '1);
    acc(0, 1, 16'h00d0, {16'h0100, base}, 0);
    acc(1, 0, base + 16'h4, 32'h0, '1);
    acc(1, 1, base, '1, 0);
    acc(0, 1, 16'h00d0, {16'h0181, base}, 0);
    acc(1, 0, base, 32'h0, '1);
    acc(1, 1, base, '1, 0);
    acc(1, 1, base + 16'(12 * ch + 12), 32'h3, 0);
    acc(1, 1, base + 16'(12 * ch + 16), 32'h2, 0);
    serial_off = 1;
    acc(1, 1, base + 16'(12 * ch + 20), 32'h8000_0003, 0);
    for (int i = 0; i < 200 && irq_line === 16'h0; i++) @(negedge core_clk);
    chk(edges, 3);
    chk(hi_len, 2);
    chk(irq_line, 16'h0200);
    acc(1, 0, base + 16'h4, 32'h1 << ch, '1);
    acc(1, 0, base + 16'(12 * ch + 20), 32'h2000_0000, 32'h2000_0000);
    for (int c = 0; c < 16; c++) begin
      if (c != 0 && irqn[c] == 0) continue;
      acc(0, 1, 16'h00d0, {12'h018, c[3:0], base}, 0);
      @(negedge core_clk);
      chk(irq_line, irqn[c] != 0 ? 16'h1 << irqn[c] : 16'h0);
    end
    acc(1, 1, base, 32'h0, 0);
    @(negedge core_clk);
    chk(irq_line, 16'h0);
    acc(1, 1, base + 16'h4, 32'h1 << ch, 0);
    acc(1, 0, base + 16'h4, 32'h0, '1);
    acc(1, 1, base + 16'(12 * ch + 20), 32'hc000_0000, 0);
    acc(1, 1, base + 16'h8, '1, 0);
    e0 = edges;
    repeat (20) @(negedge core_clk);
    chk(edges == e0, 1);
    acc(1, 1, base + 16'h8, 32'h0, 0);
    repeat (30) @(negedge core_clk);
    chk(edges > e0 + 3, 1);
    serial_off = 0;
    // Let a rise launched before the gate reach the load first
    repeat (2) @(negedge core_clk);
    e0 = edges;
    repeat (20) @(negedge core_clk);
    chk(edges == e0, 1);
    serial_off = 1;
    acc(1, 1, base + 16'(12 * ch + 20), 32'h0, 0);
    acc(0, 1, 16'h00d0, {16'h0081, base}, 0);
    acc(1, 1, base + 16'(12 * ch + 20), 32'h8000_0001, 0);
    repeat (40) @(negedge core_clk);
    // Two slow ticks of five cycles, shortened by the free divider phase
    chk(hi_len >= 6 && hi_len <= 10, 1);
    close_out;
  end
endmodule
`default_nettype wire

/* hw/msp_defs.vh */
// Constants for the 32-channel servo pulse generator.
// Assumes inclusion by bare name from hw/msp_servo.v.
`ifndef MSP_DEFS_VH
`define MSP_DEFS_VH

// Configuration space register
`define MSP_CFG_OFS     8'hd0
`define MSP_CFG_RESET   32'h0000_0000
`define MSP_CFG_WMASK   32'h018f_fe00
`define MSP_CLKSEL_BIT  24
`define MSP_DECEN_BIT   23
`define MSP_IRQR_HI     19
`define MSP_IRQR_LO     16
`define MSP_BASE_HI     15
`define MSP_BASE_LO     9

// I/O block offsets
`define MSP_OFS_MASK    9'h000
`define MSP_OFS_STAT    9'h004
`define MSP_OFS_LOCK    9'h008
`define MSP_OFS_CH0     9'h00c
`define MSP_CH_STRIDE   9'h00c
`define MSP_SUB_LOW     9'h000
`define MSP_SUB_HIGH    9'h004
`define MSP_SUB_CTRL    9'h008

// Channel control word
`define MSP_CTL_RUN     31
`define MSP_CTL_CONT    30
`define MSP_CTL_FIN     29
`define MSP_CNT_W       29

// Timing
`define MSP_CORE_HZ     50000000
`define MSP_SLOW_HZ     10000000
`define MSP_DIV_SLOW    (`MSP_CORE_HZ / `MSP_SLOW_HZ)
// Last divider count, one below the slow division ratio
`define MSP_DIV_LAST    3'h4

`endif

/* hw/msp_servo.v */
// Servo pulse-width generator: config register plus I/O register block.
// Assumes single-cycle read/write strobes synchronous to core_clk.
//
// Contract
// - Thirty-two independent servo channels via I/O registers
// - Pins shared with serial port; gated
// - All channels share one interrupt line
// - Mask register gates channels onto interrupt
// - Status register records finishing channels
// - Sync register aligns multiple channel outputs
// - Control word finish field is pollable
// - Bit 23 enables I/O decode, reset off
// - Bits 19-16 route interrupt to line
// - Bits 15-9 hold I/O base address
// - Bits 8-0 read zero, ignore writes
// - Twelve-byte group: low and high widths
// - Control word: counted or continuous pulses
// - Lock register at offset 8 holds outputs
`timescale 1ns/1ps
`default_nettype none
`include "msp_defs.vh"

module msp_servo #(
  parameter NCH = 32
) (
  input  wire        core_clk,    // 50 MHz clock
  input  wire        nrst,        // Async reset, active low
  input  wire        cfg_wr,      // Config write strobe
  input  wire        cfg_rd,      // Config read strobe
  input  wire [7:0]  cfg_addr,    // Config byte offset
  input  wire [31:0] cfg_wdata,   // Config write data
  output reg  [31:0] cfg_rdata,   // Config read data
  input  wire        io_wr,       // I/O write strobe
  input  wire        io_rd,       // I/O read strobe
  input  wire [15:0] io_addr,     // I/O byte address
  input  wire [31:0] io_wdata,    // I/O write data
  output reg  [31:0] io_rdata,    // I/O read data
  output reg         io_hit,      // Last access decoded here
  input  wire        serial_off,  // Serial port pin function off
  output reg  [31:0] servo_pin,   // Servo pulse pins
  output reg  [15:0] irq_line     // Routed interrupt lines
);

  reg  [31:0] cfg;
  reg  [31:0] imask;
  reg  [31:0] istat;
  reg  [31:0] lock;
  reg  [31:0] low_w  [0:NCH-1];
  reg  [31:0] high_w [0:NCH-1];
  reg  [31:0] tcnt   [0:NCH-1];
  reg  [`MSP_CNT_W-1:0] rem [0:NCH-1];
  reg  [NCH-1:0] run;
  reg  [NCH-1:0] cont;
  reg  [NCH-1:0] fin;
  reg  [NCH-1:0] phase;
  reg  [2:0]  div;
  reg  [NCH-1:0] ph_end;
  reg  [NCH-1:0] done_ev;
  reg  [31:0] rd_mux;
  reg  [15:0] route;
  reg  [31:0] stat_clr;
  reg  [31:0] next_istat;
  reg  [31:0] next_cfg;
  reg  [NCH-1:0] next_pin;
  reg  [NCH-1:0] ch_wr;
  integer     i;
  integer     j;
  integer     k;
  integer     m;

  // Header constants held at the widths of the signals they meet
  localparam [7:0] CFG_OFS  = `MSP_CFG_OFS;
  localparam [2:0] DIV_LAST = `MSP_DIV_LAST;

  // Slow mode ticks once per five core cycles; the divider phase is free,
  // so the first slow tick after a start lands one to five cycles later
  wire       clk_fast = cfg[`MSP_CLKSEL_BIT];
  wire       tick     = clk_fast | (div == DIV_LAST);
  wire       io_sel   = cfg[`MSP_DECEN_BIT] &
                        (io_addr[15:9] ==
                         cfg[`MSP_BASE_HI:`MSP_BASE_LO]);
  wire [8:0] off      = io_addr[8:0];
  wire [8:0] rel      = off - `MSP_OFS_CH0;
  wire [8:0] chn9     = rel / `MSP_CH_STRIDE;
  wire [8:0] sub      = rel - chn9 * `MSP_CH_STRIDE;
  wire [4:0] chn      = chn9[4:0];
  wire       in_ch    = (off >= `MSP_OFS_CH0) && (chn9 < NCH);
  wire       wr_ok    = io_wr & io_sel;
  wire       cfg_hit  = (cfg_addr[7:2] == CFG_OFS[7:2]);
  wire       irq_any  = |(istat & imask);

  // Slow tick divider; free-running in slow mode, held at zero while the fast clock is selected
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div <= 3'h0;
    end else if (clk_fast || tick) begin
      div <= 3'h0;
    end else begin
      div <= div + 3'h1;
    end
  end

  // Phase end and completion per channel; the one-bit-wider compare keeps
  // an all-ones width from wrapping, and a zero width still lasts a tick
  always @* begin
    for (j = 0; j < NCH; j = j + 1) begin
      ph_end[j] = tick & run[j] & ~lock[j] &
                  (({1'b0, tcnt[j]} + 33'h1) >=
                   {1'b0, (phase[j] ? high_w[j] : low_w[j])});
      done_ev[j] = ph_end[j] & ~phase[j] & ~cont[j] &
                   (rem[j] <= `MSP_CNT_W'h1);
    end
  end

  // Status next state; a finishing channel wins over a write-one clear,
  // and the bit stands until cleared so software may poll instead
  always @* begin
    stat_clr = 32'h0000_0000;
    if (wr_ok && off == `MSP_OFS_STAT) begin
      stat_clr = io_wdata;
    end
    next_istat = (istat & ~stat_clr) | done_ev;
  end

  // One-hot channel write select, decoded once for all engines,
  // so an offset outside the channel groups reaches no engine
  always @* begin
    for (m = 0; m < NCH; m = m + 1) begin
      ch_wr[m] = wr_ok & in_ch & (chn == m[4:0]);
    end
  end

  // Interrupt routing table; reserved codes route nowhere
  always @* begin
    route = 16'h0000;
    case (cfg[`MSP_IRQR_HI:`MSP_IRQR_LO])
      4'h1: route = 16'h0200;
      4'h2: route = 16'h0008;
      4'h3: route = 16'h0400;
      4'h4: route = 16'h0010;
      4'h5: route = 16'h0020;
      4'h6: route = 16'h0080;
      4'h7: route = 16'h0040;
      4'h8: route = 16'h0002;
      4'h9: route = 16'h0800;
      4'hb: route = 16'h1000;
      4'hd: route = 16'h4000;
      4'hf: route = 16'h8000;
      default: route = 16'h0000;
    endcase
  end

  // I/O read mux
  always @* begin
    rd_mux = 32'h0000_0000;
    if (off == `MSP_OFS_MASK) begin
      rd_mux = imask;
    end else if (off == `MSP_OFS_STAT) begin
      rd_mux = istat;
    end else if (off == `MSP_OFS_LOCK) begin
      rd_mux = lock;
    end else if (in_ch) begin
      case (sub)
        `MSP_SUB_LOW:  rd_mux = low_w[chn];
        `MSP_SUB_HIGH: rd_mux = high_w[chn];
        `MSP_SUB_CTRL: rd_mux = {run[chn], cont[chn], fin[chn],
                                 rem[chn]};
        default:       rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Config next state; reserved and always-zero bits never take a one
  always @* begin
    next_cfg = cfg;
    if (cfg_wr && cfg_hit) begin
      next_cfg = cfg_wdata & `MSP_CFG_WMASK;
    end
  end

  // Configuration register; only documented fields are writable
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg       <= `MSP_CFG_RESET;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      if (cfg_rd) begin
        cfg_rdata <= cfg_hit ? cfg : 32'h0000_0000;
      end
    end
  end

  // Bus answer registers; read data holds until the next read,
  // so a slow host may take it any cycle after the strobe
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 32'h0000_0000;
      io_hit   <= 1'b0;
    end else begin
      io_hit <= (io_rd | io_wr) & io_sel;
      if (io_rd) begin
        io_rdata <= io_sel ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Mask, status and lock registers; lock doubles as the sync register:
  // lock a group, program it, then release all of it in one write
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      imask <= 32'h0000_0000;
      istat <= 32'h0000_0000;
      lock  <= 32'h0000_0000;
    end else begin
      if (wr_ok && off == `MSP_OFS_MASK) begin
        imask <= io_wdata;
      end
      if (wr_ok && off == `MSP_OFS_LOCK) begin
        lock <= io_wdata;
      end
      istat <= next_istat;
    end
  end

  // Channel engines
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run      <= {NCH{1'b0}};
      cont     <= {NCH{1'b0}};
      fin      <= {NCH{1'b0}};
      phase    <= {NCH{1'b0}};
      for (i = 0; i < NCH; i = i + 1) begin
        low_w[i]  <= 32'h0000_0000;
        high_w[i] <= 32'h0000_0000;
        tcnt[i]   <= 32'h0000_0000;
        rem[i]    <= {`MSP_CNT_W{1'b0}};
      end
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        if (ph_end[i]) begin
          tcnt[i]  <= 32'h0000_0000;
          phase[i] <= ~phase[i];
          if (!phase[i] && !cont[i]) begin
            rem[i] <= rem[i] - `MSP_CNT_W'h1;
          end
          if (done_ev[i]) begin
            run[i]   <= 1'b0;
            fin[i]   <= 1'b1;
            phase[i] <= 1'b0;
            rem[i]   <= {`MSP_CNT_W{1'b0}};
          end
        end else if (tick && run[i] && !lock[i]) begin
          tcnt[i] <= tcnt[i] + 32'h1;
        end
        if (ch_wr[i]) begin
          if (sub == `MSP_SUB_LOW) begin
            low_w[i] <= io_wdata;
          end
          if (sub == `MSP_SUB_HIGH) begin
            high_w[i] <= io_wdata;
          end
          if (sub == `MSP_SUB_CTRL) begin
            // A write restarts the channel; clearing the run bit stops it
            run[i]   <= io_wdata[`MSP_CTL_RUN];
            cont[i]  <= io_wdata[`MSP_CTL_CONT];
            fin[i]   <= 1'b0;
            phase[i] <= io_wdata[`MSP_CTL_RUN];
            tcnt[i]  <= 32'h0000_0000;
            rem[i]   <= io_wdata[`MSP_CNT_W-1:0];
          end
        end
      end
    end
  end

  // Pin level per channel; locked channels sit low for a group release.
  // Serial mode keeps every pin low so the shared port sees no pulses
  always @* begin
    for (k = 0; k < NCH; k = k + 1) begin
      next_pin[k] = serial_off & run[k] & phase[k] &
                    ~lock[k];
    end
  end

  // Pins and interrupt outputs
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      servo_pin <= 32'h0000_0000;
      irq_line  <= 16'h0000;
    end else begin
      servo_pin <= next_pin;
      irq_line <= irq_any ? route : 16'h0000;
    end
  end

endmodule

`default_nettype wire
